// *** design/qdec_core.sv ***
/*
  Quadrature decoder top: position integrator, direction tracking,
  velocity capture with prescaler and reloading period timer, and four
  event flags with mask and clear.
  Assumes encoder inputs are synchronous or slow and that software holds
  the configuration inputs steady while changing modes.
*/
// Contract
// [R1] Follow input transitions up to quarter clock rate.
// [R2] Raise index, timer, direction and error events.
// [R3] Software enables position before velocity capture.
// [R4] Swap option exchanges channels before decoding.
// [R5] Format selector picks quadrature or clock/direction.
// [R6] Clock step moves position by direction level.
// [R7] Edge selector zero counts A, one both.
// [R8] A leading counts up, B leading down.
// [R9] Same-channel edge pair reports direction change.
// [R10] Wrap selector one: index clears position.
// [R11] Backward from zero loads the programmed maximum.
// [R12] Software programs limit as edges minus one.
// [R13] Wrap selector zero: wrap at maximum, ignore index.
// [R14] Velocity counts edges with position edge selection.
// [R15] Previous period result readable while accumulating.
// [R16] Period end copies count, clears, restarts.
// [R17] Timer counts down, reloads at zero, signals.
// [R18] Prescaler divides velocity edges by power two.
// [R19] Each event has raw, mask, masked, clear.
// [R20] Format selector one decodes clock and direction.
// [R21] Velocity capture runs only while enabled.
// [R22] Invert controls act before other processing.
// [R23] Freeze counting while halted if stall set.
// [R24] Both channels changing together is phase error.
// [R25] Inputs pass two synchroniser flip-flops first.
`include "qdec_defines.svh"

module qdec_core
  import qdec_pkg::*;
#(
  parameter int POS_W   = 32, // Width of the position counter.
  parameter int VEL_W   = 32, // Width of velocity accumulator and result.
  parameter int TIMER_W = 32  // Width of the velocity period timer.
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  input  wire logic                        encChanA,
  input  wire logic                        encChanB,
  input  wire logic                        indexInput,
  input  wire logic                        positionEnable,
  input  wire logic                        velocityCaptureOn,
  input  wire logic                        swapChannels,
  input  wire logic                        signalFormatSel,
  input  wire logic                        edgeCountSel,
  input  wire logic                        wrapSourceSel,
  input  wire logic [`QDEC_PRESCALE_W-1:0] velocityPrescale,
  input  wire logic                        invertChanA,
  input  wire logic                        invertChanB,
  input  wire logic                        invertIndex,
  input  wire logic                        debugFreezeOn,
  input  wire logic                        cpuHalted,
  input  wire logic [POS_W-1:0]            positionLimit,
  input  wire logic [TIMER_W-1:0]          velocityPeriodReload,
  input  wire logic [`QDEC_EVT_COUNT-1:0]  eventMask,
  input  wire logic [`QDEC_EVT_COUNT-1:0]  eventClear,
  output logic      [POS_W-1:0]            position,
  output logic                             direction,
  output logic      [VEL_W-1:0]            velocityAccumulator,
  output logic      [VEL_W-1:0]            velocityResult,
  output logic      [TIMER_W-1:0]          velocityTimer,
  output logic      [`QDEC_EVT_COUNT-1:0]  rawStatus,
  output logic      [`QDEC_EVT_COUNT-1:0]  maskedStatus,
  output logic                             eventIrq
);

  // Whole state of the decoder core, registered as one word.
  typedef struct packed {
    logic [POS_W-1:0]             position;  // Position counter.
    logic                         direction; // One while moving forward.
    logic [VEL_W-1:0]             velAcc;    // Edges of the running period.
    logic [VEL_W-1:0]             velResult; // Edges of the last full period.
    logic [TIMER_W-1:0]           velTimer;  // Down-counting period timer.
    logic [`QDEC_PRESC_CNT_W-1:0] presc;     // Prescaler edge counter.
    qdec_evt_t                    raw;       // Sticky event flags.
    qdec_evt_t                    masked;    // Flags gated by the mask.
    logic                         irq;       // Any masked flag set.
  } qdec_core_s;

  qdec_core_s st;    // Registered state.
  qdec_core_s next_; // Next state.

  // Decode terms computed each cycle.
  qdec_fmt_e  fmt;        // Selected signal format.
  logic       aEdge;      // Channel A changed this cycle.
  logic       bEdge;      // Channel B changed this cycle.
  logic       idxRise;    // Index line rose this cycle.
  logic       frozen;     // Counting halted for debug.
  logic       phaseErr;   // Illegal gray-code transition seen.
  logic       edgeFwd;    // Direction implied by a quadrature edge.
  logic       step;       // One counted edge or clock step.
  logic       stepFwd;    // Direction of that step.
  logic       dirSample;  // An edge that reveals the direction.
  logic       dirValue;   // The direction it reveals.
  logic       velPass;    // Step that survives the prescaler.
  qdec_evt_t  evt;        // Events raised this cycle.

  // Carrier to the conditioner.
  qdec_edge_if edgeBus ();

  assign edgeBus.invertChanA  = invertChanA;
  assign edgeBus.invertChanB  = invertChanB;
  assign edgeBus.invertIndex  = invertIndex;
  assign edgeBus.swapChannels = swapChannels;

  // Synchroniser, inversion and swap live in the conditioner.
  qdec_input_cond u_cond (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .encChanA   (encChanA),
    .encChanB   (encChanB),
    .indexInput (indexInput),
    .edgeBus    (edgeBus)
  );

  // Mask of low prescale-counter bits that must all be one to pass a step.
  function automatic logic [`QDEC_PRESC_CNT_W-1:0] prescMask(
    input logic [`QDEC_PRESCALE_W-1:0] div
  );
    prescMask = `QDEC_PRESC_ALL >> (`QDEC_PRESC_TOP - div);
  endfunction : prescMask

  // Edge, direction and error decode.
  always_comb begin
    fmt     = qdec_fmt_e'(signalFormatSel);
    frozen  = debugFreezeOn & cpuHalted; // R23
    // One-cycle history suffices because inputs toggle at most every fourth clock.
    aEdge   = edgeBus.cur.chanA ^ edgeBus.prev.chanA; // R1
    bEdge   = edgeBus.cur.chanB ^ edgeBus.prev.chanB;
    idxRise = edgeBus.cur.index & ~edgeBus.prev.index;
    // After an A edge, A differs from B when A leads; after a B edge they match.
    edgeFwd = aEdge ? (edgeBus.cur.chanA ^ edgeBus.cur.chanB)
                    : ~(edgeBus.cur.chanA ^ edgeBus.cur.chanB); // R8
    unique case (fmt) // R5
      QDEC_FMT_QUAD: begin
        phaseErr  = aEdge & bEdge; // R24
        // The edge selector only picks which edges move the count.
        step      = (aEdge | (edgeCountSel & bEdge)) & ~phaseErr; // R7
        stepFwd   = edgeFwd; // R8
        // Every legal edge reveals direction, so a same-channel pair flips it.
        dirSample = (aEdge | bEdge) & ~phaseErr; // R9
        dirValue  = edgeFwd; // R9
      end
      QDEC_FMT_CLKDIR: begin
        phaseErr  = 1'b0;
        // A rising clock edge is one step; channel B gives the sense.
        step      = aEdge & edgeBus.cur.chanA; // R6 R20
        stepFwd   = edgeBus.cur.chanB; // R6
        dirSample = step;
        dirValue  = edgeBus.cur.chanB;
      end
    endcase
  end

  // Position, velocity and event next-state logic.
  always_comb begin
    next_   = st;
    evt     = '0;
    velPass = 1'b0;

    // Position integrator, halted while frozen.
    if (positionEnable && !frozen) begin
      if (wrapSourceSel && idxRise) begin
        // Index homes the count; it wins over a step in the same cycle.
        next_.position = POS_W'(`QDEC_POS_RESET); // R10
      end else if (step && stepFwd) begin
        // Wrap at the limit; also catches a limit lowered below the count.
        if (st.position >= positionLimit) begin
          next_.position = POS_W'(`QDEC_POS_RESET); // R13
        end else begin
          next_.position = st.position + POS_W'(1); // R8
        end
      end else if (step) begin
        if (st.position == POS_W'(`QDEC_POS_RESET)) begin
          next_.position = positionLimit; // R11
        end else begin
          next_.position = st.position - POS_W'(1); // R8
        end
      end
      if (dirSample) begin
        next_.direction = dirValue;
        evt[`QDEC_EVT_DIRECTION] = (dirValue != st.direction); // R9 R2
      end
      // The index event is raised in both wrap modes; only the count ignores it.
      evt[`QDEC_EVT_INDEX]     = idxRise; // R2 R13
      evt[`QDEC_EVT_PHASE_ERR] = phaseErr; // R2 R24
    end

    // Velocity capture; it sees no steps unless the integrator runs.
    if (!velocityCaptureOn) begin
      // Idle capture restarts a full period when it is enabled again.
      next_.velAcc   = VEL_W'(`QDEC_VEL_RESET); // R21
      next_.velTimer = velocityPeriodReload; // R21
      next_.presc    = '0;
    end else if (!frozen) begin
      if (step && positionEnable) begin
        // Same step stream as the position integrator.
        next_.presc = st.presc + `QDEC_PRESC_CNT_W'(1); // R14 R3
        velPass     = ((st.presc & prescMask(velocityPrescale))
                       == prescMask(velocityPrescale)); // R18
      end
      if (st.velTimer == TIMER_W'(`QDEC_TIMER_RESET)) begin
        // A step in the closing cycle still belongs to the closing period.
        next_.velResult = st.velAcc + VEL_W'(velPass); // R16 R15
        next_.velAcc    = VEL_W'(`QDEC_VEL_RESET); // R16
        next_.velTimer  = velocityPeriodReload; // R17
        evt[`QDEC_EVT_TIMER] = 1'b1; // R17 R2
      end else begin
        next_.velAcc   = st.velAcc + VEL_W'(velPass); // R14
        next_.velTimer = st.velTimer - TIMER_W'(1); // R17
      end
    end

    // Sticky flags: a new event wins over a clear in the same cycle.
    next_.raw    = (st.raw & ~eventClear) | evt; // R19
    next_.masked = next_.raw & eventMask; // R19
    next_.irq    = |next_.masked;
  end

  // State register; everything clears on reset.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_;
    end
  end

  // Outputs come straight from the state register.
  assign position            = st.position;
  assign direction           = st.direction;
  assign velocityAccumulator = st.velAcc;
  assign velocityResult      = st.velResult;
  assign velocityTimer       = st.velTimer;
  assign rawStatus           = st.raw;
  assign maskedStatus        = st.masked;
  assign eventIrq            = st.irq;

endmodule : qdec_core

// *** design/qdec_defines.svh ***
/*
  Constants of the quadrature decoder: event bit positions, field widths
  and reset values of the counters.
  Assumes it is included by bare name; the guard allows more than one inclusion per compilation unit.
*/
`ifndef QDEC_DEFINES_SVH
`define QDEC_DEFINES_SVH

// Bit positions of the four events in the status and mask vectors.
`define QDEC_EVT_INDEX     0
`define QDEC_EVT_TIMER     1
`define QDEC_EVT_DIRECTION 2
`define QDEC_EVT_PHASE_ERR 3
`define QDEC_EVT_COUNT     4

// Width of the velocity prescale field and of its edge counter.
`define QDEC_PRESCALE_W    3
`define QDEC_PRESC_CNT_W   7
`define QDEC_PRESC_ALL     7'h7f
`define QDEC_PRESC_TOP     3'h7

// Reset values of counters and flags.
`define QDEC_POS_RESET     32'h0000_0000
`define QDEC_VEL_RESET     32'h0000_0000
`define QDEC_TIMER_RESET   32'h0000_0000
`define QDEC_EVT_RESET     4'h0

`endif

// *** design/qdec_pkg.sv ***
/*
  Types shared by the quadrature decoder modules.
  Assumes qdec_defines.svh is reachable on the include path.
*/
`include "qdec_defines.svh"

package qdec_pkg;

  // One sample of the three conditioned encoder lines.
  typedef struct packed {
    logic chanA;  // Phase A, or step clock in clock/direction format.
    logic chanB;  // Phase B, or direction level in clock/direction format.
    logic index;  // Index line.
  } qdec_lvl_s;

  // Vector of the four event flags.
  typedef logic [`QDEC_EVT_COUNT-1:0] qdec_evt_t;

  // Signal format of the two channels.
  typedef enum logic {
    QDEC_FMT_QUAD   = 1'b0,
    QDEC_FMT_CLKDIR = 1'b1
  } qdec_fmt_e;

endpackage : qdec_pkg

// *** design/qdec_edge_if.sv ***
/*
  Carrier between the input conditioner and the decoder core: the core
  hands down the invert and swap controls and receives the current and
  previous conditioned samples.
  Assumes qdec_pkg is compiled first.
*/
interface qdec_edge_if import qdec_pkg::*; ();

  logic      invertChanA;  // Invert phase A before anything else.
  logic      invertChanB;  // Invert phase B before anything else.
  logic      invertIndex;  // Invert the index line before anything else.
  logic      swapChannels; // Exchange A and B before decoding.
  qdec_lvl_s cur;          // Conditioned sample of this cycle.
  qdec_lvl_s prev;         // Conditioned sample one cycle earlier.

  modport cond (input invertChanA, invertChanB, invertIndex, swapChannels, output cur, prev);
  modport core (output invertChanA, invertChanB, invertIndex, swapChannels, input cur, prev);

endinterface : qdec_edge_if

// *** design/qdec_input_cond.sv ***
/*
  Input conditioner of the quadrature decoder: two-stage synchroniser,
  inversion, channel swap and a one-cycle history for edge detection.
  Assumes the encoder lines toggle no faster than a quarter of sys_clk.
*/
`include "qdec_defines.svh"

module qdec_input_cond
  import qdec_pkg::*;
(
  input wire logic  sys_clk,
  input wire logic  rstn,
  input wire logic  encChanA,
  input wire logic  encChanB,
  input wire logic  indexInput,
  qdec_edge_if.cond edgeBus
);

  // Whole state of the conditioner.
  typedef struct packed {
    qdec_lvl_s meta;   // First synchroniser stage, read only by the second.
    qdec_lvl_s stable; // Second synchroniser stage.
    qdec_lvl_s cur;    // Inverted and swapped sample.
    qdec_lvl_s prev;   // Previous conditioned sample.
  } qdec_cond_s;

  qdec_cond_s st;    // Registered state.
  qdec_cond_s next_; // Next state.

  // Synchronise, then invert and swap the settled levels.
  always_comb begin
    next_.meta   = '{chanA: encChanA, chanB: encChanB, index: indexInput}; // R25
    next_.stable = st.meta; // R25
    // Inversion is applied first so that the swap moves the corrected phases.
    next_.cur.index = st.stable.index ^ edgeBus.invertIndex; // R22
    if (edgeBus.swapChannels) begin
      next_.cur.chanA = st.stable.chanB ^ edgeBus.invertChanB; // R4
      next_.cur.chanB = st.stable.chanA ^ edgeBus.invertChanA; // R4
    end else begin
      next_.cur.chanA = st.stable.chanA ^ edgeBus.invertChanA; // R22
      next_.cur.chanB = st.stable.chanB ^ edgeBus.invertChanB; // R22
    end
    next_.prev = st.cur;
  end

  // State register; all lines rest low after reset.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_;
    end
  end

  assign edgeBus.cur  = st.cur;
  assign edgeBus.prev = st.prev;

endmodule : qdec_input_cond

// *** bench/qdec_core_props.sv ***
/*
  Checker for the quadrature decoder: velocity timer, accumulator, freeze,
  position range and event flag relations.
  Assumes it is bound to qdec_core and sees only that module's ports.
*/
`include "qdec_defines.svh"

module qdec_core_props #(
  parameter int POS_W   = 32,
  parameter int VEL_W   = 32,
  parameter int TIMER_W = 32
) (
  input wire logic                       sys_clk,
  input wire logic                       rstn,
  input wire logic                       velocityCaptureOn,
  input wire logic                       debugFreezeOn,
  input wire logic                       cpuHalted,
  input wire logic                       wrapSourceSel,
  input wire logic [POS_W-1:0]           positionLimit,
  input wire logic [TIMER_W-1:0]         velocityPeriodReload,
  input wire logic [`QDEC_EVT_COUNT-1:0] eventMask,
  input wire logic [POS_W-1:0]           position,
  input wire logic [VEL_W-1:0]           velocityAccumulator,
  input wire logic [TIMER_W-1:0]         velocityTimer,
  input wire logic [`QDEC_EVT_COUNT-1:0] rawStatus,
  input wire logic [`QDEC_EVT_COUNT-1:0] maskedStatus,
  input wire logic                       eventIrq
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Freeze needs both the option and the halt, so one alone never stalls.
  wire logic frz = debugFreezeOn && cpuHalted;

  // Capture running and the timer at zero in the same cycle: the two conditions of an expiry.
  sequence s_run;
    velocityCaptureOn && !frz;
  endsequence
  sequence s_expire;
    s_run ##0 (velocityTimer == '0);
  endsequence

  a_timer_reload: assert property (s_expire |=> velocityTimer == $past(velocityPeriodReload) && rawStatus[1])
    else $error("timer did not reload or flag at expiry");
  a_acc_clear: assert property (s_expire |=> velocityAccumulator == '0)
    else $error("accumulator not cleared at expiry");
  a_timer_down: assert property (s_run ##0 (velocityTimer != '0) |=> velocityTimer == $past(velocityTimer) - 1'b1)
    else $error("timer did not count down by one");
  a_off_idle: assert property (!velocityCaptureOn && !frz |=> velocityAccumulator == '0
                               && velocityTimer == $past(velocityPeriodReload))
    else $error("velocity logic ran while disabled");
  a_freeze_hold: assert property (frz |=> $stable(position) && $stable(velocityTimer) && $stable(velocityAccumulator))
    else $error("counting moved while frozen");
  a_mask_view: assert property (maskedStatus == (rawStatus & $past(eventMask)))
    else $error("masked status differs from raw and mask");
  a_irq_any: assert property (eventIrq == |(rawStatus & $past(eventMask)))
    else $error("interrupt line differs from masked events");
  a_pos_range: assert property (!wrapSourceSel && position <= positionLimit |=> position <= $past(positionLimit))
    else $error("position left the range up to the limit");
endmodule : qdec_core_props

bind qdec_core qdec_core_props #(.POS_W(POS_W), .VEL_W(VEL_W), .TIMER_W(TIMER_W)) uProps (
  .sys_clk, .rstn, .velocityCaptureOn, .debugFreezeOn, .cpuHalted, .wrapSourceSel, .positionLimit,
  .velocityPeriodReload, .eventMask, .position, .velocityAccumulator, .velocityTimer, .rawStatus,
  .maskedStatus, .eventIrq);

// *** bench/qdec_enc_model.sv ***
/*
  Behavioural incremental encoder driving the two channel lines and index.
  Assumes the bench calls its tasks and that sys_clk runs throughout.
*/
module qdec_enc_model (
  input  wire logic sys_clk,
  output logic      encChanA,
  output logic      encChanB,
  output logic      indexInput
);
  timeunit 1ns;
  timeprecision 1ns;

  // Index stays low; the bench produces index pulses through the inverter.
  initial begin
    encChanA = 1'b0;
    encChanB = 1'b0;
    indexInput = 1'b0;
  end

  // Gray-code steps, each held seven clocks so lines never beat a quarter clock.
  task automatic quad(input logic fwd, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      if ((encChanA == encChanB) == fwd) encChanA = ~encChanA;
      else encChanB = ~encChanB;
      repeat (6) @(negedge sys_clk);
    end
  endtask : quad

  // Step clock on A with the direction level on B.
  task automatic cdir(input logic dir, input int n);
    @(negedge sys_clk);
    encChanA = 1'b0;
    encChanB = dir;
    repeat (6) @(negedge sys_clk);
    for (int i = 0; i < n; i++) begin
      encChanA = 1'b1;
      repeat (6) @(negedge sys_clk);
      encChanA = 1'b0;
      repeat (6) @(negedge sys_clk);
    end
  endtask : cdir
endmodule : qdec_enc_model

// *** bench/qdec_core_tb.sv ***
/*
  Self-checking bench of the quadrature decoder with an encoder model.
  Assumes the checker is bound to qdec_core and default parameters.
*/
`include "qdec_defines.svh"

module qdec_core_tb;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {int k; logic [31:0] v;} qdec_note_s;
  logic        sys_clk, rstn, encChanA, encChanB, indexInput, positionEnable, velocityCaptureOn;
  logic        swapChannels, signalFormatSel, edgeCountSel, wrapSourceSel, invertChanA, invertChanB;
  logic        invertIndex, debugFreezeOn, cpuHalted, direction, eventIrq;
  logic [2:0]  velocityPrescale;
  logic [3:0]  eventMask, eventClear, rawStatus, maskedStatus;
  logic [31:0] positionLimit, velocityPeriodReload, position, velocityAccumulator, velocityResult, velocityTimer;
  logic [7:0]  lf;     // Random source, stepped by nxt.
  int          nFail, checkCount, n;
  qdec_note_s  q[$];   // Expectations waiting for the monitor.
  event        seen;

  qdec_enc_model uEnc (.sys_clk, .encChanA, .encChanB, .indexInput);
  qdec_core uut (.sys_clk, .rstn, .encChanA, .encChanB, .indexInput, .positionEnable, .velocityCaptureOn,
    .swapChannels, .signalFormatSel, .edgeCountSel, .wrapSourceSel, .velocityPrescale, .invertChanA,
    .invertChanB, .invertIndex, .debugFreezeOn, .cpuHalted, .positionLimit, .velocityPeriodReload,
    .eventMask, .eventClear, .position, .direction, .velocityAccumulator, .velocityResult, .velocityTimer,
    .rawStatus, .maskedStatus, .eventIrq);

  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nxt
  task automatic note(input int k, input logic [31:0] v);
    q.push_back('{k, v});
  endtask : note
  task automatic check();
    ->seen;
    #1;
  endtask : check
  task automatic tick(input int c);
    repeat (c) @(negedge sys_clk);
  endtask : tick
  // Waits for the timer flag; a limit that runs out counts as a mismatch.
  task automatic waitExpiry();
    for (int i = 0; i < 1000 && rawStatus[1] !== 1'b1; i++) tick(1);
    if (rawStatus[1] !== 1'b1) nFail++;
  endtask : waitExpiry
  // A one-cycle clear pulse, so no flag is held cleared across a test.
  task automatic clr();
    @(negedge sys_clk) eventClear = 4'hf;
    @(negedge sys_clk) eventClear = 4'h0;
  endtask : clr
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      nFail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrapUp

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Monitor: takes every queued expectation, oldest first, and compares each with the live output.
  always begin
    qdec_note_s e;
    @(seen);
    while (q.size() > 0) begin
      e = q.pop_front();
      case (e.k)
        0: cmp("position", e.v, position);
        1: cmp("velocityResult", e.v, velocityResult);
        2: cmp("velocityAccumulator", e.v, velocityAccumulator);
        3: cmp("rawStatus", e.v, {28'h0, rawStatus});
        4: cmp("eventIrq", e.v, {31'h0, eventIrq});
        default: cmp("direction", e.v, {31'h0, direction});
      endcase
    end
  end

  // Watchdog: the whole sequence needs about 2,000 clocks, a tenth of this span.
  initial begin
    #200000;
    nFail++;
    wrapUp();
  end

  initial begin
    {rstn, positionEnable, velocityCaptureOn, swapChannels, signalFormatSel, edgeCountSel} = '0;
    {wrapSourceSel, invertChanA, invertChanB, invertIndex, debugFreezeOn, cpuHalted} = '0;
    {velocityPrescale, eventClear} = '0;
    eventMask = 4'h2;
    positionLimit = 32'h63;
    lf = 8'h38;
    velocityPeriodReload = 32'h78 + lf;
    tick(4);
    rstn = 1'b1;
    note(0, 32'h0);
    note(3, 32'h0);
    check();
    $display("test reset done");
    positionEnable = 1'b1;
    edgeCountSel = 1'b1;
    lf = nxt(lf);
    n = lf % 20 + 3;
    uEnc.quad(1'b1, n);
    note(0, n);
    note(3, 32'h4);
    note(5, 32'h1);
    check();
    clr();
    uEnc.quad(1'b0, 2);
    note(0, n - 2);
    note(5, 32'h0);
    note(3, 32'h4);
    check();
    edgeCountSel = 1'b0;
    uEnc.quad(1'b1, 4);
    note(0, n);
    check();
    edgeCountSel = 1'b1;
    uEnc.quad(1'b0, n + 1);
    note(0, 32'h63);
    check();
    uEnc.quad(1'b1, 1);
    note(0, 32'h0);
    check();
    swapChannels = 1'b1;
    uEnc.quad(1'b1, 2);
    note(0, 32'h62);
    check();
    swapChannels = 1'b0;
    $display("test position done");
    clr();
    {invertChanA, invertChanB} = 2'b11;
    tick(6);
    note(3, 32'h8);
    note(0, 32'h62);
    check();
    {invertChanA, invertChanB} = 2'b00;
    tick(6);
    clr();
    wrapSourceSel = 1'b1;
    invertIndex = 1'b1;
    tick(6);
    note(0, 32'h0);
    note(3, 32'h1);
    check();
    invertIndex = 1'b0;
    tick(6);
    wrapSourceSel = 1'b0;
    uEnc.quad(1'b1, 3);
    invertIndex = 1'b1;
    tick(6);
    note(0, 32'h3);
    check();
    invertIndex = 1'b0;
    $display("test error and index done");
    signalFormatSel = 1'b1;
    uEnc.cdir(1'b1, 3);
    note(0, 32'h6);
    check();
    uEnc.cdir(1'b0, 2);
    note(0, 32'h4);
    note(5, 32'h0);
    check();
    signalFormatSel = 1'b0;
    {debugFreezeOn, cpuHalted} = 2'b11;
    uEnc.quad(1'b1, 2);
    note(0, 32'h4);
    check();
    {cpuHalted, positionEnable} = 2'b00;
    uEnc.quad(1'b1, 2);
    note(0, 32'h4);
    check();
    {debugFreezeOn, positionEnable} = 2'b01;
    $display("test format and freeze done");
    for (int p = 0; p < 4; p++) begin
      velocityPrescale = p[2:0];
      velocityCaptureOn = 1'b0;
      tick(2);
      velocityCaptureOn = 1'b1;
      waitExpiry();
      clr();
      note(4, 32'h0);
      uEnc.quad(1'b1, 8);
      note(2, 32'h8 >> p);
      note(1, 32'h0);
      check();
      waitExpiry();
      note(1, 32'h8 >> p);
      note(4, 32'h1);
      check();
      clr();
    end
    $display("test velocity done");
    wrapUp();
  end
endmodule : qdec_core_tb
